// File: core/cmc_map.vh
/*
 * Constants for the configurable macrocell logic block: word indices of the
 * configuration registers, field positions inside them and reset values.
 * Assumes a register port with byte addresses and one 32-bit word per register.
 */
`ifndef CMC_MAP_VH
`define CMC_MAP_VH

// Word indices (byte address = index * 4)
`define CMC_IDX_GLOBAL      6'h00
`define CMC_IDX_STATUS      6'h01
`define CMC_IDX_CT_LO       6'h04
`define CMC_IDX_CT_HI       6'h0A
`define CMC_IDX_CELL_HI     2'h1

// Global register fields
`define CMC_GLB_FLOAT_EN    0
`define CMC_GLB_GLOBAL_DUAL_MODE_CLOCK_ASYNC  1
`define CMC_GLB_SRC_LSB     4
`define CMC_GLB_SRC_MSB     7
`define CMC_GLB_RESET       8'h00

// Control term high word fields
`define CMC_CTH_MASK_MSB    3
`define CMC_CTH_OR_MODE     8

// Macrocell configuration word fields
`define CMC_CFG_WIDTH       9
`define CMC_CFG_MODE_LSB    0
`define CMC_CFG_MODE_MSB    1
`define CMC_CFG_CLK_LSB     2
`define CMC_CFG_CLK_MSB     3
`define CMC_CFG_FALLING     4
`define CMC_CFG_PR_EN       5
`define CMC_CFG_OE_LSB      6
`define CMC_CFG_OE_MSB      8
`define CMC_CFG_RESET       9'h000

// Storage modes
`define CMC_MODE_COMB       2'h0
`define CMC_MODE_D          2'h1
`define CMC_MODE_T          2'h2

// Clock sources
`define CMC_CLK_SYNC        2'h0
`define CMC_CLK_DUAL        2'h1
`define CMC_CLK_CT_A        2'h2
`define CMC_CLK_CT_B        2'h3

// Output enable sources
`define CMC_OE_OFF          3'h0
`define CMC_OE_ON           3'h1
`define CMC_OE_CT_A         3'h2
`define CMC_OE_CT_B         3'h3
`define CMC_OE_CT_C         3'h4
`define CMC_OE_CT_D         3'h5

`endif

// File: core/cmc_ctrl_term.v
/*
 * One control term: an AND or an OR of any selection of the block inputs.
 * Assumes inputs arrive on the system clock; the result is combinational.
 */
`timescale 1ns/1ps

module cmc_ctrl_term #(
	parameter NIN = 36
) (
	input  wire [NIN-1:0] termIn,
	input  wire [NIN-1:0] useMask,
	input  wire           orMode,
	output wire           termOut
);

	// Unused inputs are neutral: one for AND, zero for OR
	assign termOut = orMode ? |(termIn & useMask) : &(termIn | ~useMask);

endmodule // cmc_ctrl_term

// File: core/cmc_macrocell.v
/*
 * One macrocell: storage element as D, T or combinational path, clock
 * source choice, preset/reset gating and output enable choice.
 * Assumes clock sources arrive as one-cycle edge pulses on clk_sys.
 */
`timescale 1ns/1ps
`include "cmc_map.vh"

module cmc_macrocell (
	input  wire                      clk_sys,
	input  wire                      rstn,
	input  wire [`CMC_CFG_WIDTH-1:0] cfg,
	input  wire                      sumIn,
	input  wire                      syncRise,
	input  wire                      syncFall,
	input  wire                      dualRise,
	input  wire                      dualFall,
	input  wire                      ctClkA,
	input  wire                      ctClkB,
	input  wire                      presetTerm,
	input  wire                      resetTerm,
	input  wire [3:0]                oeTerms,
	output reg                       state,
	output wire                      cellOut,
	output reg                       oeWant
);

	wire [1:0] mode;
	wire [1:0] clkSel;
	wire [2:0] oeSel;
	reg        clkEdge;
	reg        next_state;

	assign mode   = cfg[`CMC_CFG_MODE_MSB:`CMC_CFG_MODE_LSB];
	assign clkSel = cfg[`CMC_CFG_CLK_MSB:`CMC_CFG_CLK_LSB];
	assign oeSel  = cfg[`CMC_CFG_OE_MSB:`CMC_CFG_OE_LSB];

	// Clock source pick; polarity only for the two global clocks
	always @* begin
		case (clkSel)
		`CMC_CLK_SYNC: clkEdge = cfg[`CMC_CFG_FALLING] ? syncFall : syncRise;
		`CMC_CLK_DUAL: clkEdge = cfg[`CMC_CFG_FALLING] ? dualFall : dualRise;
		`CMC_CLK_CT_A: clkEdge = ctClkA;
		default:       clkEdge = ctClkB;
		endcase
	end

	// Reset term beats preset term; both beat the clock, as asynchronous controls do
	always @* begin
		next_state = state;
		if (cfg[`CMC_CFG_PR_EN] && resetTerm) begin
			next_state = 1'b0;
		end else if (cfg[`CMC_CFG_PR_EN] && presetTerm) begin
			next_state = 1'b1;
		end else if (clkEdge) begin
			if (mode == `CMC_MODE_T) begin
				next_state = state ^ sumIn;
			end else begin
				next_state = sumIn;
			end
		end
	end

	// Storage starts at zero, as after power-up
	always @(posedge clk_sys) begin
		if (!rstn) begin
			state <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// Combinational mode bypasses the storage element
	assign cellOut = (mode == `CMC_MODE_COMB) ? sumIn : state;

	// Output enable choice
	always @* begin
		case (oeSel)
		`CMC_OE_ON:   oeWant = 1'b1;
		`CMC_OE_CT_A: oeWant = oeTerms[0];
		`CMC_OE_CT_B: oeWant = oeTerms[1];
		`CMC_OE_CT_C: oeWant = oeTerms[2];
		`CMC_OE_CT_D: oeWant = oeTerms[3];
		default:      oeWant = 1'b0;
		endcase
	end

endmodule // cmc_macrocell

// File: core/cmc_logic_block.v
/*
 * Logic block of sixteen configurable macrocells with six shared control
 * terms, two global clocks, a global output float pin, pad and cell feedback
 * toward the interconnect array, and a plain configuration register port.
 * Assumes interconnect inputs and summed terms are on clk_sys; the global
 * clock pins, float pin and pad inputs are asynchronous and are synchronised.
 * All clock sources are sampled and turned into edge pulses on clk_sys.
 */
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "cmc_map.vh"

module cmc_logic_block #(
	parameter NIN   = 36,
	parameter NCELL = 16,
	parameter NCT   = 6
) (
	input  wire             clk_sys,
	input  wire             rstn,
	input  wire [7:0]       regAddr,
	input  wire [31:0]      regWdata,
	input  wire             regWr,
	input  wire             regRd,
	output reg  [31:0]      regRdata,
	input  wire [NIN-1:0]   icInput,
	input  wire [NCELL-1:0] sumTerm,
	input  wire             globalSyncClock,
	input  wire             globalDualModeClock,
	input  wire             globalOutputFloatPin_n,
	input  wire [NCELL-1:0] padIn,
	output reg  [NCELL-1:0] padOut,
	output reg  [NCELL-1:0] padOe,
	output reg  [NCELL-1:0] fbMacro,
	output reg  [NCELL-1:0] fbPin
);

	wire [5:0]           wIdx;
	reg  [7:0]           glbCfg;
	reg  [NIN-1:0]       ctMask [0:NCT-1];
	reg  [NCT-1:0]       ctOr;
	reg  [`CMC_CFG_WIDTH-1:0] cellCfg [0:NCELL-1];
	wire [NCT-1:0]       ctVal;
	reg  [1:0]           ctPrev;
	wire                 ctClkA;
	wire                 ctClkB;
	wire [NCELL-1:0]     cellState;
	wire [NCELL-1:0]     cellOut;
	wire [NCELL-1:0]     cellOe;
	reg  [31:0]          next_rdata;
	integer              iCt;
	integer              iCell;
	integer              iRd;

	assign wIdx = regAddr[7:2];

	// Three-stage synchronisers; a change is taken once stages two and three agree
	reg [2:0] syncClkS;
	reg [2:0] dualClkS;
	reg [2:0] floatS;
	reg       syncClkLvl;
	reg       dualPinLvl;
	reg       floatLvl_n;
	reg [NCELL-1:0] padS1;
	reg [NCELL-1:0] padS2;
	reg [NCELL-1:0] padS3;
	reg [NCELL-1:0] padLvl;

	// First global clock pin; only an outside pin may feed it
	always @(posedge clk_sys) begin
		if (!rstn) begin
			syncClkS   <= 3'h0;
			syncClkLvl <= 1'b0;
		end else begin
			syncClkS <= {syncClkS[1:0], globalSyncClock};
			if (syncClkS[1] == syncClkS[2]) begin
				syncClkLvl <= syncClkS[2];
			end
		end
	end

	// Second global clock pin; used while the cell equation source is off
	always @(posedge clk_sys) begin
		if (!rstn) begin
			dualClkS   <= 3'h0;
			dualPinLvl <= 1'b0;
		end else begin
			dualClkS <= {dualClkS[1:0], globalDualModeClock};
			if (dualClkS[1] == dualClkS[2]) begin
				dualPinLvl <= dualClkS[2];
			end
		end
	end

	// Float pin idles high, so the filter starts there and no float follows reset
	always @(posedge clk_sys) begin
		if (!rstn) begin
			floatS     <= 3'h7;
			floatLvl_n <= 1'b1;
		end else begin
			floatS <= {floatS[1:0], globalOutputFloatPin_n};
			if (floatS[1] == floatS[2]) begin
				floatLvl_n <= floatS[2];
			end
		end
	end

	// Pads: each bit changes only when stages two and three agree
	always @(posedge clk_sys) begin
		if (!rstn) begin
			padS1  <= {NCELL{1'b0}};
			padS2  <= {NCELL{1'b0}};
			padS3  <= {NCELL{1'b0}};
			padLvl <= {NCELL{1'b0}};
		end else begin
			padS1  <= padIn;
			padS2  <= padS1;
			padS3  <= padS2;
			padLvl <= (padS2 & padS3) | (padLvl & (padS2 ^ padS3));
		end
	end

	// Second global clock: pin, or a cell equation taken from its registered feedback
	wire       dualAsync;
	wire [3:0] dualSrc;
	wire       dualLvl;
	reg        syncPrev;
	reg        dualPrev;
	wire       syncRise;
	wire       syncFall;
	wire       dualRise;
	wire       dualFall;

	assign dualAsync = glbCfg[`CMC_GLB_GLOBAL_DUAL_MODE_CLOCK_ASYNC];
	assign dualSrc   = glbCfg[`CMC_GLB_SRC_MSB:`CMC_GLB_SRC_LSB];
	// Registered feedback avoids a loop through the cell's own clock
	assign dualLvl   = dualAsync ? fbMacro[dualSrc] : dualPinLvl;

	// Edge tracker of the first global clock
	always @(posedge clk_sys) begin
		if (!rstn) begin
			syncPrev <= 1'b0;
		end else begin
			syncPrev <= syncClkLvl;
		end
	end

	// Edge tracker of the second clock; a change of source may show as one edge
	always @(posedge clk_sys) begin
		if (!rstn) begin
			dualPrev <= 1'b0;
		end else begin
			dualPrev <= dualLvl;
		end
	end

	// Edges exist only as one-cycle pulses; a pin must stay two samples per level

	assign syncRise = syncClkLvl & ~syncPrev;
	assign syncFall = ~syncClkLvl & syncPrev;
	assign dualRise = dualLvl & ~dualPrev;
	assign dualFall = ~dualLvl & dualPrev;

	// Six shared control terms over the block inputs
	genvar k;
	generate
		for (k = 0; k < NCT; k = k + 1) begin : gCt
			cmc_ctrl_term #(
				.NIN     (NIN)
			) uTerm (
				.termIn  (icInput),
				.useMask (ctMask[k]),
				.orMode  (ctOr[k]),
				.termOut (ctVal[k])
			);
		end
	endgenerate

	// Control term clocks count on their rising edge only
	// The tracker follows the terms through reset: an empty AND term reads one
	// and would otherwise fake an edge right after reset
	always @(posedge clk_sys) begin
		if (!rstn) begin
			ctPrev <= ctVal[3:2];
		end else begin
			ctPrev <= ctVal[3:2];
		end
	end

	// Term clocks have no polarity choice

	assign ctClkA = ctVal[2] & ~ctPrev[0];
	assign ctClkB = ctVal[3] & ~ctPrev[1];

	// Sixteen macrocells share the terms of the block
	genvar c;
	generate
		for (c = 0; c < NCELL; c = c + 1) begin : gCell
			cmc_macrocell uCell (
				.clk_sys    (clk_sys),
				.rstn       (rstn),
				.cfg        (cellCfg[c]),
				.sumIn      (sumTerm[c]),
				.syncRise   (syncRise),
				.syncFall   (syncFall),
				.dualRise   (dualRise),
				.dualFall   (dualFall),
				.ctClkA     (ctClkA),
				.ctClkB     (ctClkB),
				.presetTerm (ctVal[0]),
				.resetTerm  (ctVal[1]),
				.oeTerms    (ctVal[5:2]),
				.state      (cellState[c]),
				.cellOut    (cellOut[c]),
				.oeWant     (cellOe[c])
			);
		end
	endgenerate

	// Pad drive, float and both feedback paths; all registered
	wire floatAll;
	assign floatAll = glbCfg[`CMC_GLB_FLOAT_EN] & ~floatLvl_n;

	// Pad drive and enable; the float pin overrides every enable
	always @(posedge clk_sys) begin
		if (!rstn) begin
			padOut <= {NCELL{1'b0}};
			padOe  <= {NCELL{1'b0}};
		end else begin
			padOut <= cellOut;
			padOe  <= floatAll ? {NCELL{1'b0}} : cellOe;
		end
	end

	// Both feedback paths; the pad path sees the pin even while the cell drives it
	always @(posedge clk_sys) begin
		if (!rstn) begin
			fbMacro <= {NCELL{1'b0}};
			fbPin   <= {NCELL{1'b0}};
		end else begin
			fbMacro <= cellOut;
			fbPin   <= padLvl;
		end
	end

	// Global configuration word
	always @(posedge clk_sys) begin
		if (!rstn) begin
			glbCfg <= `CMC_GLB_RESET;
		end else if (regWr && wIdx == `CMC_IDX_GLOBAL) begin
			glbCfg <= regWdata[7:0];
		end
	end

	// Control term masks and modes; each mask spans a low and a high word
	always @(posedge clk_sys) begin
		if (!rstn) begin
			ctOr <= {NCT{1'b0}};
			for (iCt = 0; iCt < NCT; iCt = iCt + 1) begin
				ctMask[iCt] <= {NIN{1'b0}};
			end
		end else if (regWr) begin
			for (iCt = 0; iCt < NCT; iCt = iCt + 1) begin
				if (wIdx == `CMC_IDX_CT_LO + iCt) begin
					ctMask[iCt][31:0] <= regWdata;
				end
				if (wIdx == `CMC_IDX_CT_HI + iCt) begin
					ctMask[iCt][NIN-1:32] <= regWdata[`CMC_CTH_MASK_MSB:0];
					ctOr[iCt]             <= regWdata[`CMC_CTH_OR_MODE];
				end
			end
		end
	end

	// Cell configuration writes; configuration is meant to be static in use
	// A rewrite while the chosen clock moves can cost or add one capture
	always @(posedge clk_sys) begin
		if (!rstn) begin
			for (iCell = 0; iCell < NCELL; iCell = iCell + 1) begin
				cellCfg[iCell] <= `CMC_CFG_RESET;
			end
		end else if (regWr && wIdx[5:4] == `CMC_IDX_CELL_HI) begin
			cellCfg[wIdx[3:0]] <= regWdata[`CMC_CFG_WIDTH-1:0];
		end
	end

	// Read decode; unmapped words read zero
	// Status shows stored bits, so a combinational cell reads the storage that its chosen clock still loads
	always @* begin
		next_rdata = 32'h00000000;
		case (wIdx)
		`CMC_IDX_GLOBAL: begin
			next_rdata[7:0] = glbCfg;
		end
		`CMC_IDX_STATUS: begin
			next_rdata = {fbPin, cellState};
		end
		default: begin
			next_rdata = 32'h00000000;
		end
		endcase
		for (iRd = 0; iRd < NCT; iRd = iRd + 1) begin
			if (wIdx == `CMC_IDX_CT_LO + iRd) begin
				next_rdata = ctMask[iRd][31:0];
			end
			if (wIdx == `CMC_IDX_CT_HI + iRd) begin
				next_rdata[`CMC_CTH_MASK_MSB:0] = ctMask[iRd][NIN-1:32];
				next_rdata[`CMC_CTH_OR_MODE]    = ctOr[iRd];
			end
		end
		if (wIdx[5:4] == `CMC_IDX_CELL_HI) begin
			next_rdata[`CMC_CFG_WIDTH-1:0] = cellCfg[wIdx[3:0]];
		end
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge clk_sys) begin
		if (!rstn) begin
			regRdata <= 32'h00000000;
		end else if (regRd) begin
			regRdata <= next_rdata;
		end else begin
			regRdata <= 32'h00000000;
		end
	end

endmodule // cmc_logic_block

// File: verif/cmc_properties.sv
/* Port checker for the macrocell logic block.
   Assumes a bind to cmc_logic_block; shadows the float enable bit of the global word and cell 0. */
`timescale 1ns/1ps
`include "cmc_map.vh"
module cmc_properties #(
	parameter NCELL = 16
) (
	input wire             clk_sys,
	input wire             rstn,
	input wire [7:0]       regAddr,
	input wire [31:0]      regWdata,
	input wire             regWr,
	input wire             regRd,
	input wire [31:0]      regRdata,
	input wire [NCELL-1:0] sumTerm,
	input wire             globalOutputFloatPin_n,
	input wire [NCELL-1:0] padIn,
	input wire [NCELL-1:0] padOe,
	input wire [NCELL-1:0] fbMacro,
	input wire [NCELL-1:0] fbPin
);
	reg        glbFloat;
	reg  [8:0] cfg0;
	wire       comb0 = cfg0[1:0] == `CMC_MODE_COMB && !cfg0[5];
	wire [2:0] oe0   = cfg0[8:6];
	// Shadows take writes on the same edge as the design does
	always @(posedge clk_sys) begin
		if (!rstn) begin
			glbFloat <= 1'b0;
			cfg0     <= `CMC_CFG_RESET;
		end else if (regWr && regAddr[7:2] == `CMC_IDX_GLOBAL)
			glbFloat <= regWdata[0];
		else if (regWr && regAddr[7:2] == 6'h10)
			cfg0     <= regWdata[8:0];
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_reset_quiet: assert property (
		$rose(rstn) |-> padOe == 0 && fbMacro == 0 && fbPin == 0)
		else $error("outputs not clear after reset");
	a_rdata_idle: assert property (regRdata != 32'h0 |-> $past(regRd))
		else $error("read data outside its slot");
	a_comb_pass: assert property (
		comb0 [*2] |-> fbMacro[0] == $past(sumTerm[0]))
		else $error("combinational cell does not pass its sum");
	a_oe_off: assert property (
		(oe0 == `CMC_OE_OFF || oe0 > 3'h5) [*3] |-> !padOe[0])
		else $error("fixed-off buffer drives");
	a_oe_on: assert property (
		(oe0 == `CMC_OE_ON && (!glbFloat || globalOutputFloatPin_n)) [*6] |-> padOe[0])
		else $error("fixed-on buffer floats");
	a_float_all: assert property (
		(glbFloat && !globalOutputFloatPin_n) [*6] |-> padOe == {NCELL{1'b0}})
		else $error("float pin did not release the outputs");
	a_pad_feedback: assert property ($stable(padIn) [*8] |-> fbPin == padIn)
		else $error("pad feedback does not follow the pad");
	a_status_pins: assert property (
		regRd && regAddr[7:2] == `CMC_IDX_STATUS |=> regRdata[31:16] == $past(fbPin))
		else $error("status word lacks the pad feedback");
	c_float: cover property ((glbFloat && !globalOutputFloatPin_n) [*6]);
	c_comb: cover property (comb0 && oe0 == `CMC_OE_ON ##1 padOe[0]);
	c_status: cover property (regRd && regAddr[7:2] == `CMC_IDX_STATUS);
endmodule // cmc_properties

bind cmc_logic_block cmc_properties #(.NCELL(NCELL)) u_cmc_properties (
	.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sumTerm(sumTerm),
	.globalOutputFloatPin_n(globalOutputFloatPin_n), .padIn(padIn),
	.padOe(padOe), .fbMacro(fbMacro), .fbPin(fbPin));

// File: verif/cmc_array_model.sv
/* Model of the term arrays and interconnect that feed the logic block.
   Assumes the bench posts wanted levels on clk_sys; outputs are registered. */
`timescale 1ns/1ps
module cmc_array_model (
	input  wire        clk_sys,
	input  wire [35:0] wantIc,
	input  wire [15:0] wantSum,
	input  wire        wantSync,
	output reg  [35:0] icInput = 36'h0,
	output reg  [15:0] sumTerm = 16'h0,
	output reg         globalSyncClock = 1'b0
);
	// One cycle of array settling, so no level reaches the block early
	always @(posedge clk_sys) begin
		icInput         <= wantIc;
		sumTerm         <= wantSum;
		globalSyncClock <= wantSync; // driven from outside only
	end
endmodule // cmc_array_model

// File: verif/testbench.sv
/* Self-checking bench for the macrocell logic block.
   Assumes the array model and the bound checker are compiled beside it. */
`timescale 1ns/1ps
module testbench;
	reg         clk_sys = 1'b0;
	reg         rstn = 1'b0;
	reg  [7:0]  regAddr = 8'h00;
	reg  [31:0] regWdata = 32'h0;
	reg         regWr = 1'b0;
	reg         regRd = 1'b0;
	reg  [35:0] wantIc = 36'h0;
	reg  [15:0] wantSum = 16'h0;
	reg         wantSync = 1'b0;
	reg         floatPin_n = 1'b1;
	reg         dualPin = 1'b0;
	reg  [15:0] padIn = 16'h0;
	wire [31:0] regRdata;
	wire [35:0] icInput;
	wire [15:0] sumTerm, padOut, padOe, fbMacro, fbPin;
	wire        syncClk;
	int         bad_count = 0;
	int         comparisons = 0;
	// Rows: {output enable code, expected padOe of cell 0}; empty term masks read 1
	logic [3:0] rows [0:7] = '{4'h0, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB, 4'hC, 4'hE};

	cmc_array_model u_cmc_array_model (.clk_sys(clk_sys), .wantIc(wantIc),
		.wantSum(wantSum), .wantSync(wantSync), .icInput(icInput),
		.sumTerm(sumTerm), .globalSyncClock(syncClk));
	cmc_logic_block u_cmc_logic_block (.clk_sys(clk_sys), .rstn(rstn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .icInput(icInput), .sumTerm(sumTerm),
		.globalSyncClock(syncClk), .globalDualModeClock(dualPin),
		.globalOutputFloatPin_n(floatPin_n), .padIn(padIn), .padOut(padOut),
		.padOe(padOe), .fbMacro(fbMacro), .fbPin(fbPin));

	always #12.5 clk_sys = ~clk_sys;

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Waits past the edge so that its updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	// Sync pin level; waits out the pin filter and the cell path
	task automatic sclk(input logic v);
		@(posedge clk_sys);
		wantSync <= v;
		cyc(8);
	endtask
	// Second clock pin level; same wait as the first clock
	task automatic dpin(input logic v);
		@(posedge clk_sys);
		dualPin <= v;
		cyc(8);
	endtask
	task automatic sum(input logic [15:0] v);
		@(posedge clk_sys);
		wantSum <= v;
	endtask
	task automatic ic(input logic [35:0] v);
		@(posedge clk_sys);
		wantIc <= v;
		cyc(4);
	endtask
	function automatic logic [31:0] cw(input logic [1:0] m, c, input logic f, p,
			input logic [2:0] o);
		return {23'h0, o, p, f, c, m};
	endfunction
	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// A hang counts against the run; the tests need well under this
	initial begin
		cyc(4000);
		bad_count++;
		results();
	end

	initial begin : main
		logic [31:0] d;
		int          i;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(8'h40, d);
		chk("cell0 reset", 32'h0, d);
		rd(8'h04, d);
		chk("status reset", 32'h0, d);
		wr(8'h80, 32'hFFFFFFFF);
		rd(8'h80, d);
		chk("unmapped", 32'h0, d);
		for (i = 0; i < 8; i++) begin
			wr(8'h40, cw(2'h0, 2'h0, 1'b0, 1'b0, rows[i][3:1]));
			cyc(3);
			chk("padOe0", {31'h0, rows[i][0]}, {31'h0, padOe[0]});
		end
		// Combinational path, then pad used as input on cell 1
		wr(8'h40, cw(2'h0, 2'h0, 1'b0, 1'b0, 3'h1));
		sum(16'h0001);
		padIn <= 16'hA5C2;
		cyc(8);
		chk("comb padOut", 32'h1, {31'h0, padOut[0]});
		chk("pad feedback", 32'hA5C2, {16'h0, fbPin});
		rd(8'h04, d);
		chk("status", 32'hA5C20000, d);
		chk("cell feedback", 32'h1, {31'h0, fbMacro[0]});
		wr(8'h00, 32'h1);
		@(posedge clk_sys);
		floatPin_n <= 1'b0;
		cyc(6);
		chk("float", 32'h0, {16'h0, padOe});
		@(posedge clk_sys);
		floatPin_n <= 1'b1;
		cyc(6);
		chk("unfloat", 32'h1, {31'h0, padOe[0]});
		// D on rising, then falling edge of the first global clock
		wr(8'h40, cw(2'h1, 2'h0, 1'b0, 1'b0, 3'h1));
		sclk(1'b1);
		chk("D rise", 32'h1, {31'h0, fbMacro[0]});
		sum(16'h0000);
		sclk(1'b0);
		chk("D no fall", 32'h1, {31'h0, fbMacro[0]});
		wr(8'h40, cw(2'h1, 2'h0, 1'b1, 1'b0, 3'h1));
		sclk(1'b1);
		chk("Df no rise", 32'h1, {31'h0, fbMacro[0]});
		sclk(1'b0);
		chk("Df fall", 32'h0, {31'h0, fbMacro[0]});
		// Toggle mode: toggle, hold, toggle back
		wr(8'h40, cw(2'h2, 2'h0, 1'b0, 1'b0, 3'h1));
		sum(16'h0001);
		sclk(1'b1);
		chk("T toggle", 32'h1, {31'h0, fbMacro[0]});
		sum(16'h0000);
		sclk(1'b0);
		sclk(1'b1);
		chk("T hold", 32'h1, {31'h0, fbMacro[0]});
		sum(16'h0001);
		sclk(1'b0);
		sclk(1'b1);
		chk("T back", 32'h0, {31'h0, fbMacro[0]});
		// Term clocks: AND of one input, OR of two inputs
		wr(8'h18, 32'h1);
		wr(8'h1C, 32'h6);
		wr(8'h34, 32'h100);
		wr(8'h40, cw(2'h1, 2'h2, 1'b0, 1'b0, 3'h1));
		ic(36'h1);
		chk("term2 clock", 32'h1, {31'h0, fbMacro[0]});
		wr(8'h40, cw(2'h1, 2'h3, 1'b0, 1'b0, 3'h1));
		sum(16'h0000);
		ic(36'h2);
		chk("term3 or clock", 32'h0, {31'h0, fbMacro[0]});
		// Preset and reset: gated off, then on, then both at once
		wr(8'h10, 32'h10);
		wr(8'h14, 32'h20);
		wr(8'h40, cw(2'h1, 2'h0, 1'b0, 1'b0, 3'h1));
		ic(36'h10);
		chk("preset gated", 32'h0, {31'h0, fbMacro[0]});
		wr(8'h40, cw(2'h1, 2'h0, 1'b0, 1'b1, 3'h1));
		cyc(3);
		chk("preset", 32'h1, {31'h0, fbMacro[0]});
		ic(36'h30);
		chk("reset wins", 32'h0, {31'h0, fbMacro[0]});
		ic(36'h0);
		// Second global clock made by cell 1's equation
		wr(8'h00, 32'h12);
		wr(8'h40, cw(2'h1, 2'h1, 1'b0, 1'b0, 3'h1));
		sum(16'h0001);
		cyc(4);
		sum(16'h0003);
		cyc(8);
		chk("cell clock", 32'h1, {31'h0, fbMacro[0]});
		// Second clock from its pin; mode 3 acts as D, falling edge chosen
		wr(8'h00, 32'h0);
		wr(8'h40, cw(2'h3, 2'h1, 1'b1, 1'b0, 3'h1));
		sum(16'h0000);
		dpin(1'b1);
		chk("dual no rise", 32'h1, {31'h0, fbMacro[0]});
		dpin(1'b0);
		chk("dual fall", 32'h0, {31'h0, fbMacro[0]});
		results();
	end
endmodule // testbench
